/* File: verilog/synth_link_pkg.sv */
/*
 package for the synthesizer status register link: frame field layout, reset
 values, the controller's register map and its state encoding.
 assumes both link ends and the bench import it whole.
*/
package synth_link_pkg;

   // ----------------------------------------------------------------
   // frame layout (bit 31 travels first)
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 32;
   localparam logic [5:0] FRAME_BITS_W = 6'h20;
   localparam logic [2:0] TAG_REG7 = 3'h7;
   localparam int POS_DIG_LOST = 31;
   localparam int POS_ANA_LOST = 30;
   localparam int POS_FRAME_ERR = 29;
   localparam int POS_REV_LSB = 25;
   localparam int POS_PART_LSB = 21;
   localparam int POS_WIDE = 20;
   localparam int POS_KEEP_ONE = 19;
   localparam int POS_EXTMOD_LSB = 12;
   localparam int POS_EXTNUM_LSB = 8;
   localparam int POS_EDGE = 7;
   localparam int POS_TARGET_LSB = 4;
   localparam int POS_READ_REQ = 3;
   localparam int POS_TAG_LSB = 0;

   // ----------------------------------------------------------------
   // device reset values
   // ----------------------------------------------------------------
   localparam logic RST_WIDE = 1'b0;
   localparam logic RST_EDGE = 1'b1;
   localparam logic [3:0] RST_EXT = 4'h0;
   localparam logic [2:0] RST_TARGET = 3'h0;
   localparam logic [15:0] MOD_MIN = 16'h0002;

   // ----------------------------------------------------------------
   // controller register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_TX = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_RX = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam int CTRL_WRITE = 0;
   localparam int CTRL_READ = 1;
   localparam int CTRL_EDGE = 2;
   localparam int CTRL_LEN_LSB = 8;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_READ = 1;
   localparam logic [1:0] RST_IRQ_MASK = 2'h0;
   localparam int SCLK_HALF_DEFAULT = 16;
   localparam int SCLK_HALF_MIN = 12;

   // ----------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LOW = 3'b001,
      H_HIGH = 3'b010,
      H_TAIL = 3'b011,
      H_GAP = 3'b100
   } host_state_t;

endpackage

/* File: verilog/synth_link_if.sv */
/*
 serial link between the controller and the status register.
 assumes the bench instantiates it once and joins both modports.
*/
`timescale 1ns/1ps
interface synth_link_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;

   modport device (input sclk, input cs_n, input sdi, output sdo);
   modport host (output sclk, output cs_n, output sdi, input sdo);
endinterface

/* File: verilog/synth_status_readback_reg.sv */
/*
 device end: the status and readback control register, its serial slave and
 the readback shifter.
 assumes the link pins are asynchronous to ref_clk_i and that the clock
 half-period is at least six ref_clk_i cycles; lock events come from logic
 on ref_clk_i.
*/
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module synth_status_readback_reg
   import synth_link_pkg::*;
#(
   parameter logic [2:0] REVISION = 3'h2, // arbitrary value
   parameter logic [3:0] PART = 4'h5 // arbitrary value
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   synth_link_if.device link,
   input wire logic dig_lock_lost_i,
   input wire logic band_select_event_i,
   input wire logic [11:0] sub_integer_numerator_i,
   input wire logic [11:0] modulus_i,
   input wire logic [31:0] readback_data_i,
   output logic [2:0] readout_target_field_o,
   output logic wide_resolution_select_o,
   output logic [3:0] numerator_low_bits_o,
   output logic [3:0] modulus_low_bits_o,
   output logic [15:0] eff_numerator_o,
   output logic [15:0] eff_modulus_o,
   output logic modulus_invalid_o,
   output logic dig_unlock_sticky_o,
   output logic analog_lock_loss_o,
   output logic frame_error_o,
   output logic readback_armed_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sclk_sync;
      logic [2:0] cs_sync;
      logic [2:0] sdi_sync;
      logic sclk_lvl;
      logic cs_n_lvl;
      logic sdi_lvl;
      logic [5:0] count;
      logic [31:0] shift_in;
      logic [31:0] shift_out;
      logic sdo;
      logic dig_lost;
      logic ana_lost;
      logic frame_err;
      logic wide;
      logic [3:0] ext_mod;
      logic [3:0] ext_num;
      logic edge_fall;
      logic [2:0] target;
      logic rd_pend;
      logic [15:0] eff_num;
      logic [15:0] eff_mod;
      logic mod_bad;
   } dev_state_t;

   dev_state_t s;
   dev_state_t next_s;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic [31:0] own_word;
   logic [31:0] word;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      // first stage feeds only the second; levels change once stages 2 and 3 agree
      next_s.sclk_sync = {s.sclk_sync[1:0], link.sclk};
      next_s.cs_sync = {s.cs_sync[1:0], link.cs_n};
      next_s.sdi_sync = {s.sdi_sync[1:0], link.sdi};
      if (s.sclk_sync[1] == s.sclk_sync[2]) begin
         next_s.sclk_lvl = s.sclk_sync[2];
      end
      if (s.cs_sync[1] == s.cs_sync[2]) begin
         next_s.cs_n_lvl = s.cs_sync[2];
      end
      if (s.sdi_sync[1] == s.sdi_sync[2]) begin
         next_s.sdi_lvl = s.sdi_sync[2];
      end
      rise = (s.sclk_sync[2:1] == 2'b11) && !s.sclk_lvl;
      fall = (s.sclk_sync[2:1] == 2'b00) && s.sclk_lvl;
      start = (s.cs_sync[2:1] == 2'b00) && s.cs_n_lvl;
      stop = (s.cs_sync[2:1] == 2'b11) && !s.cs_n_lvl;

      // read-only codes come from parameters, never from the shift register
      own_word = '0;
      own_word[POS_DIG_LOST] = s.dig_lost;
      own_word[POS_ANA_LOST] = s.ana_lost;
      own_word[POS_FRAME_ERR] = s.frame_err;
      own_word[POS_REV_LSB +: 3] = REVISION;
      own_word[POS_PART_LSB +: 4] = PART;
      own_word[POS_WIDE] = s.wide;
      own_word[POS_EXTMOD_LSB +: 4] = s.ext_mod;
      own_word[POS_EXTNUM_LSB +: 4] = s.ext_num;
      own_word[POS_EDGE] = s.edge_fall;
      own_word[POS_TARGET_LSB +: 3] = s.target;
      own_word[POS_TAG_LSB +: 3] = TAG_REG7;
      word = (s.target == TAG_REG7) ? own_word : readback_data_i;

      // ----- frame handling -----
      if (start) begin
         next_s.count = '0;
         next_s.sdo = 1'b0;
         next_s.shift_out = '0;
         if (s.rd_pend) begin
            if (s.edge_fall) begin
               // falling mode: first bit must stand before the first rising edge
               next_s.sdo = word[31];
               next_s.shift_out = {word[30:0], 1'b0};
            end else begin
               next_s.shift_out = word;
            end
         end
      end else if (!s.cs_n_lvl) begin
         if (rise) begin
            if (s.count != 6'h3F) begin
               next_s.count = 6'(s.count + 6'h01);
            end
            next_s.shift_in = {s.shift_in[30:0], s.sdi_lvl};
         end
         if ((rise && !s.edge_fall) || (fall && s.edge_fall)) begin
            next_s.sdo = s.shift_out[31];
            next_s.shift_out = {s.shift_out[30:0], 1'b0};
         end
      end

      if (stop) begin
         next_s.sdo = 1'b0;
         next_s.rd_pend = 1'b0;
         if (s.count != FRAME_BITS_W) begin
            next_s.frame_err = 1'b1;
         end else if (s.shift_in[POS_TAG_LSB +: 3] == TAG_REG7) begin
            if (s.shift_in[POS_DIG_LOST]) begin
               next_s.dig_lost = 1'b0;
            end
            if (s.shift_in[POS_ANA_LOST]) begin
               next_s.ana_lost = 1'b0;
            end
            if (s.shift_in[POS_FRAME_ERR]) begin
               next_s.frame_err = 1'b0;
            end
            next_s.wide = s.shift_in[POS_WIDE];
            next_s.ext_mod = s.shift_in[POS_EXTMOD_LSB +: 4];
            next_s.ext_num = s.shift_in[POS_EXTNUM_LSB +: 4];
            next_s.edge_fall = s.shift_in[POS_EDGE];
            next_s.target = s.shift_in[POS_TARGET_LSB +: 3];
            // only arms the next frame, never stored as a field
            next_s.rd_pend = s.shift_in[POS_READ_REQ];
         end
      end

      // events after clears: a set in the clearing cycle wins
      if (dig_lock_lost_i) begin
         next_s.dig_lost = 1'b1;
      end
      if (band_select_event_i) begin
         next_s.ana_lost = 1'b1;
      end

      // ----- resolution -----
      if (s.wide) begin
         next_s.eff_num = {sub_integer_numerator_i, s.ext_num};
         next_s.eff_mod = {modulus_i, s.ext_mod};
      end else begin
         next_s.eff_num = {4'h0, sub_integer_numerator_i};
         next_s.eff_mod = {4'h0, modulus_i};
      end
      next_s.mod_bad = next_s.eff_mod < MOD_MIN;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '0;
         s.sclk_sync <= 3'h0;
         s.cs_sync <= 3'h7;
         s.cs_n_lvl <= 1'b1;
         s.wide <= RST_WIDE;
         s.ext_mod <= RST_EXT;
         s.ext_num <= RST_EXT;
         s.edge_fall <= RST_EDGE;
         s.target <= RST_TARGET;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.sdo = s.sdo;
   assign readout_target_field_o = s.target;
   assign wide_resolution_select_o = s.wide;
   assign numerator_low_bits_o = s.ext_num;
   assign modulus_low_bits_o = s.ext_mod;
   assign eff_numerator_o = s.eff_num;
   assign eff_modulus_o = s.eff_mod;
   assign modulus_invalid_o = s.mod_bad;
   assign dig_unlock_sticky_o = s.dig_lost;
   assign analog_lock_loss_o = s.ana_lost;
   assign frame_error_o = s.frame_err;
   assign readback_armed_o = s.rd_pend;

endmodule

/* File: verilog/synth_link_host.sv */
/*
 controller end: software registers, serial clock divider and frame engine.
 assumes software obeys the one-cycle strobe protocol and that the device
 answers within the clock half-period.
*/
`timescale 1ns/1ps
module synth_link_host
   import synth_link_pkg::*;
#(
   parameter int SCLK_HALF = SCLK_HALF_DEFAULT
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   synth_link_if.host link,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic irq_o
);

   // slower clocks are fine up to a half-period of 255; faster ones outrun the readback round trip
   if (SCLK_HALF < SCLK_HALF_MIN || SCLK_HALF > 255) begin : g_bad_half
      $error("SCLK_HALF out of range");
   end

   localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      host_state_t state;
      logic [7:0] div;
      logic [5:0] bits;
      logic [5:0] len;
      logic [31:0] tx;
      logic [31:0] sh;
      logic [31:0] rx;
      logic is_read;
      logic sclk;
      logic cs_n;
      logic sdi;
      logic [2:0] sdo_sync;
      logic sdo_lvl;
      logic edge_fall;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [31:0] rdata;
   } hst_state_t;

   hst_state_t s;
   hst_state_t next_s;
   logic half_end;

   always_comb begin
      next_s = s;
      next_s.sdo_sync = {s.sdo_sync[1:0], link.sdo};
      if (s.sdo_sync[1] == s.sdo_sync[2]) begin
         next_s.sdo_lvl = s.sdo_sync[2];
      end
      half_end = (s.div == HALF_LAST);
      next_s.div = (s.state == H_IDLE || half_end) ? 8'h00 : 8'(s.div + 8'h01);

      // ----------------------------------------------------------------
      // register port
      // ----------------------------------------------------------------
      next_s.rdata = '0;
      if (rd_i) begin
         case (addr_i)
            OFS_TX: next_s.rdata = s.tx;
            OFS_CTRL: next_s.rdata = {18'h0, s.len, 5'h0, s.edge_fall, 2'h0};
            OFS_STATUS: next_s.rdata = {31'h0, s.state != H_IDLE};
            OFS_RX: next_s.rdata = s.rx;
            OFS_IRQ_STAT: begin
               next_s.rdata = {30'h0, s.irq_stat};
               next_s.irq_stat = 2'h0;
            end
            OFS_IRQ_MASK: next_s.rdata = {30'h0, s.irq_mask};
            default: next_s.rdata = '0;
         endcase
      end
      if (wr_i) begin
         case (addr_i)
            OFS_TX: begin
               if (s.state == H_IDLE) begin
                  next_s.tx = wdata_i;
               end
            end
            OFS_CTRL: begin
               next_s.edge_fall = wdata_i[CTRL_EDGE];
               next_s.len = wdata_i[CTRL_LEN_LSB +: 6];
               if (s.state == H_IDLE && (wdata_i[CTRL_WRITE] || wdata_i[CTRL_READ])) begin
                  // a read frame sends zeros so no register is written by it
                  next_s.is_read = wdata_i[CTRL_READ];
                  next_s.sh = wdata_i[CTRL_READ] ? 32'h0000_0000 : s.tx;
                  next_s.sdi = wdata_i[CTRL_READ] ? 1'b0 : s.tx[31];
                  next_s.cs_n = 1'b0;
                  next_s.bits = '0;
                  next_s.state = H_LOW;
               end
            end
            OFS_IRQ_MASK: next_s.irq_mask = wdata_i[1:0];
            default: ;
         endcase
      end

      // ----------------------------------------------------------------
      // frame engine
      // ----------------------------------------------------------------
      case (s.state)
         H_IDLE: ;
         H_LOW: begin
            if (half_end) begin
               if (s.edge_fall) begin
                  next_s.rx = {s.rx[30:0], s.sdo_lvl};
               end
               next_s.sclk = 1'b1;
               next_s.state = H_HIGH;
            end
         end
         H_HIGH: begin
            if (half_end) begin
               if (!s.edge_fall) begin
                  next_s.rx = {s.rx[30:0], s.sdo_lvl};
               end
               next_s.sclk = 1'b0;
               next_s.bits = 6'(s.bits + 6'h01);
               if (6'(s.bits + 6'h01) == s.len) begin
                  next_s.state = H_TAIL;
               end else begin
                  next_s.sh = {s.sh[30:0], 1'b0};
                  next_s.sdi = s.sh[30];
                  next_s.state = H_LOW;
               end
            end
         end
         H_TAIL: begin
            if (half_end) begin
               next_s.cs_n = 1'b1;
               next_s.sdi = 1'b0;
               next_s.state = H_GAP;
            end
         end
         H_GAP: begin
            if (half_end) begin
               next_s.irq_stat[IRQ_DONE] = 1'b1;
               if (s.is_read) begin
                  next_s.irq_stat[IRQ_READ] = 1'b1;
               end
               next_s.state = H_IDLE;
            end
         end
         default: next_s.state = H_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '0;
         s.state <= H_IDLE;
         s.cs_n <= 1'b1;
         s.len <= FRAME_BITS_W;
         s.edge_fall <= RST_EDGE;
         s.irq_mask <= RST_IRQ_MASK;
      end else begin
         s <= next_s;
      end
   end

   assign link.sclk = s.sclk;
   assign link.cs_n = s.cs_n;
   assign link.sdi = s.sdi;
   assign rdata_o = s.rdata;
   assign irq_o = |(s.irq_stat & s.irq_mask);

endmodule

/* File: testbench/synth_link_asserts.sv */
/*
 checker for the status register link: sticky flags, frame length, tag
 filter and effective values.
 assumes it sits beside the link instance, all signals on ref_clk_i.
*/
`timescale 1ns/1ps
module synth_link_asserts
   import synth_link_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic dig_lock_lost_i,
   input wire logic band_select_event_i,
   input wire logic [11:0] sub_integer_numerator_i,
   input wire logic [11:0] modulus_i,
   input wire logic wide_resolution_select_o,
   input wire logic [3:0] numerator_low_bits_o,
   input wire logic [3:0] modulus_low_bits_o,
   input wire logic [15:0] eff_numerator_o,
   input wire logic [15:0] eff_modulus_o,
   input wire logic dig_unlock_sticky_o,
   input wire logic analog_lock_loss_o,
   input wire logic frame_error_o
);
   // ----------------------------------------------------------------
   // frame monitor
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sclk_q;
      logic [6:0] edges;
      logic [31:0] bits;
   } mon_t;
   mon_t mon;
   mon_t next_mon;

   // bits survive the frame end so the tag can be judged after it
   always_comb begin
      next_mon = mon;
      next_mon.sclk_q = sclk;
      if (cs_n) begin
         next_mon.edges = 7'h00;
      end else if (sclk && !mon.sclk_q) begin
         next_mon.edges = mon.edges + 7'h01;
         next_mon.bits = {mon.bits[30:0], sdi};
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mon <= '0;
      end else begin
         mon <= next_mon;
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence frame_end_s;
      $rose(cs_n);
   endsequence

   sequence good_end_s;
      $rose(cs_n) ##0 (mon.edges == 7'h20);
   endsequence

   a_dig_lost_sets: assert property (dig_lock_lost_i |-> ##[1:3] dig_unlock_sticky_o)
      else $error("digital unlock flag not set");
   // a clear lands a few cycles after the frame, so only long idle spans count
   a_dig_flag_holds: assert property ((dig_unlock_sticky_o && cs_n) [*8] |=> dig_unlock_sticky_o)
      else $error("digital unlock flag dropped without a frame");
   a_ana_lost_sets: assert property (band_select_event_i |-> ##[1:3] analog_lock_loss_o)
      else $error("analog loss flag not set");
   a_bad_len_flags: assert property (frame_end_s ##0 (mon.edges != 7'h20) |-> ##[1:8] frame_error_o)
      else $error("bad frame length not flagged");
   a_err_flag_holds: assert property ((frame_error_o && cs_n) [*8] |=> frame_error_o)
      else $error("frame error flag dropped without a frame");
   a_wide_numerator: assert property ((wide_resolution_select_o && $stable(numerator_low_bits_o)) [*2]
      |=> eff_numerator_o == {$past(sub_integer_numerator_i), $past(numerator_low_bits_o)})
      else $error("wide numerator wrong");
   a_wide_modulus: assert property ((wide_resolution_select_o && $stable(modulus_low_bits_o)) [*2]
      |=> eff_modulus_o == {$past(modulus_i), $past(modulus_low_bits_o)})
      else $error("wide modulus wrong");
   a_narrow_numerator: assert property ((!wide_resolution_select_o) [*2]
      |=> eff_numerator_o == {4'h0, $past(sub_integer_numerator_i)})
      else $error("narrow numerator wrong");
   a_tag_ignored: assert property (frame_end_s ##0 (mon.bits[2:0] != TAG_REG7)
      |=> $stable(wide_resolution_select_o) [*8])
      else $error("foreign tag changed the register");
   a_tag_applies: assert property (good_end_s ##0 (mon.bits[2:0] == TAG_REG7)
      |-> ##[1:8] wide_resolution_select_o == mon.bits[POS_WIDE])
      else $error("resolution select not taken");
endmodule

/* File: testbench/synth_status_readback_reg_tb.sv */
/*
 self-checking bench: controller and status register joined by the link.
 assumes the package, the link and both ends are compiled first.
*/
`timescale 1ns/1ps
module synth_status_readback_reg_tb;
   import synth_link_pkg::*;
   localparam logic [2:0] REV = 3'h3; // arbitrary value
   localparam logic [3:0] PART = 4'h9; // arbitrary value
   logic ref_clk, rst_n, wr, rd, irq, dig_lost, band_ev, msk, wide, dflag, aflag, ferr, mod_inv;
   logic w_s, e_s, fd, fa, ff, armed;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, rb_data, q;
   logic [11:0] num, md;
   logic [3:0] nlow, mlow, em_s, en_s;
   logic [2:0] target, t_s;
   logic [15:0] effn, effm;
   logic [12:0] f;
   int n_errors, checks_done;

   synth_link_if lnk();
   synth_link_host #(.SCLK_HALF(SCLK_HALF_MIN)) i_synth_link_host (.ref_clk_i(ref_clk),
      .rst_n_i(rst_n), .link(lnk), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .irq_o(irq));
   synth_status_readback_reg #(.REVISION(REV), .PART(PART)) i_synth_status_readback_reg (
      .ref_clk_i(ref_clk), .rst_n_i(rst_n), .link(lnk), .dig_lock_lost_i(dig_lost),
      .band_select_event_i(band_ev), .sub_integer_numerator_i(num), .modulus_i(md),
      .readback_data_i(rb_data), .readout_target_field_o(target), .wide_resolution_select_o(wide),
      .numerator_low_bits_o(nlow), .modulus_low_bits_o(mlow), .eff_numerator_o(effn),
      .eff_modulus_o(effm), .modulus_invalid_o(mod_inv), .dig_unlock_sticky_o(dflag),
      .analog_lock_loss_o(aflag), .frame_error_o(ferr), .readback_armed_o(armed));
   synth_link_asserts i_synth_link_asserts (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
      .sclk(lnk.sclk), .cs_n(lnk.cs_n), .sdi(lnk.sdi), .dig_lock_lost_i(dig_lost),
      .band_select_event_i(band_ev), .sub_integer_numerator_i(num), .modulus_i(md),
      .wide_resolution_select_o(wide), .numerator_low_bits_o(nlow), .modulus_low_bits_o(mlow),
      .eff_numerator_o(effn), .eff_modulus_o(effm), .dig_unlock_sticky_o(dflag),
      .analog_lock_loss_o(aflag), .frame_error_o(ferr));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // effective value from base and low bits, low bits ignored in narrow mode
   function automatic logic [15:0] eff_exp(input logic [11:0] base, input logic [3:0] low,
      input logic w);
      return w ? {base, low} : {4'h0, base};
   endfunction

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge ref_clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 q = rdata;
   endtask

   // polls busy rather than counting cycles, so divider changes matter only through the 2000-poll cap
   task automatic frame(input logic [31:0] tx, input logic [5:0] len, input logic rf);
      int n;
      bus(1'b1, OFS_TX, tx);
      bus(1'b1, OFS_CTRL, {18'h0, len, 5'h0, e_s, rf, !rf});
      n = 0;
      do begin
         bus(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 2000);
      if (n >= 2000)
         n_errors++;
      repeat (4) @(posedge ref_clk);
      #1 check(irq, msk);
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      check(q[1:0], {rf, 1'b1});
      repeat (2) @(posedge ref_clk);
      #1 check(irq, 1'b0);
   endtask

   task automatic wr7(input logic [2:0] clr, input logic rq, input logic [2:0] tag);
      frame({clr, 1'b0, 7'($urandom), f[12], 1'b1, 3'h0, f[11:0], rq, tag}, 6'h20, 1'b0);
      if (tag === TAG_REG7) begin
         {w_s, em_s, en_s, e_s, t_s} = f;
         fd &= !clr[2];
         fa &= !clr[1];
         ff &= !clr[0];
      end
      check({dflag, aflag, ferr, wide, mlow, nlow, target}, {fd, fa, ff, w_s, em_s, en_s, t_s});
      check(armed, rq && tag === TAG_REG7);
   endtask

   task automatic rd_back();
      frame(32'h0, 6'h20, 1'b1);
      check(armed, 1'b0);
      bus(1'b0, OFS_RX, 32'h0);
      check(q, (t_s === 3'h7) ? {fd, fa, ff, 1'b0, REV, PART, w_s, 4'h0, em_s, en_s, e_s, t_s,
         1'b0, TAG_REG7} : rb_data);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock, watchdog, sequence
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      #2_000_000;
      n_errors++;
      end_of_test();
   end

   initial begin
      {rst_n, wr, rd, dig_lost, band_ev, msk, addr, wdata, num, md, rb_data} = '0;
      {w_s, em_s, en_s, t_s, fd, fa, ff, n_errors, checks_done} = '0;
      e_s = 1'b1;
      q = $urandom(72);
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1 check({wide, mlow, nlow, target, dflag, aflag, ferr}, 15'h0);
      bus(1'b0, 8'h20, 32'h0);
      check(q, 32'h0);
      bus(1'b0, OFS_CTRL, 32'h0);
      check(q, {18'h0, FRAME_BITS_W, 5'h0, RST_EDGE, 2'h0});
      bus(1'b1, OFS_IRQ_MASK, 32'h1);
      bus(1'b0, OFS_IRQ_MASK, 32'h0);
      check(q, 32'h0000_0001);
      msk = 1'b1;
      f = {1'b0, 8'h00, 1'b1, 3'h7};
      wr7(3'h0, 1'b1, 3'h7);
      rd_back();
      // every target and both edges; modulus corners 1 and 2 at i 2 and 3
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         f = 13'($urandom);
         f[3:0] = {i[0], 3'(i)};
         if (i[1])
            f[12:8] = {1'b1, 4'(i - 1)};
         num <= 12'($urandom);
         md <= i[1] ? 12'h000 : 12'($urandom);
         rb_data <= $urandom;
         wr7(3'h0, 1'b1, 3'h7);
         check(effn, eff_exp(num, en_s, w_s));
         check(effm, eff_exp(md, em_s, w_s));
         check(mod_inv, eff_exp(md, em_s, w_s) < MOD_MIN);
         rd_back();
      end
      f = ~f;
      wr7(3'h0, 1'b0, 3'h6);
      bus(1'b1, OFS_IRQ_MASK, 32'h0);
      msk = 1'b0;
      @(posedge ref_clk);
      dig_lost <= 1'b1;
      band_ev <= 1'b1;
      @(posedge ref_clk);
      dig_lost <= 1'b0;
      band_ev <= 1'b0;
      {fd, fa} = 2'h3;
      f = {w_s, em_s, en_s, e_s, 3'h7};
      wr7(3'h1, 1'b1, 3'h7);
      rd_back();
      wr7(3'h4, 1'b0, 3'h7);
      wr7(3'h2, 1'b0, 3'h7);
      for (int k = 0; k < 2; k++) begin
         f = ~f;
         frame({11'h0, f[12], 1'b1, 3'h0, f[11:0], 1'b0, 3'h7}, k ? 6'h21 : 6'h1F, 1'b0);
         ff = 1'b1;
         check({ferr, wide, mlow, nlow, target}, {ff, w_s, em_s, en_s, t_s});
         f = {w_s, em_s, en_s, e_s, t_s};
         wr7(3'h1, 1'b0, 3'h7);
      end
      end_of_test();
   end
endmodule
